// File: verilog/dbs_pkg.sv
// Purpose: shared constants and types for the bus-sizing lane steering block
// Assumes: 32-bit external data bus, four byte lanes, lane 3 = bits 31..24
// Notes: size codes give bytes still to move; 00 stands for four
package dbs_pkg;
  // remaining-size codes on the two size outputs
  localparam logic [1:0] SIZE_LONG = 2'h0; // four bytes
  localparam logic [1:0] SIZE_BYTE = 2'h1; // one byte
  localparam logic [1:0] SIZE_WORD = 2'h2; // two bytes
  localparam logic [1:0] SIZE_TRIP = 2'h3; // three bytes
  // acknowledge encoding {upper, lower}
  localparam logic [1:0] ACK_WAIT = 2'h0; // keep waiting
  localparam logic [1:0] ACK_P8 = 2'h1; // 8-bit port
  localparam logic [1:0] ACK_P16 = 2'h2; // 16-bit port
  localparam logic [1:0] ACK_P32 = 2'h3; // 32-bit port
  // bus cycle sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1, // no transfer in progress
    ST_CYC = 3'h2, // bus cycle running, waiting for acknowledge
    ST_DONE = 3'h4 // one-cycle completion report
  } dbs_state_e;
endpackage : dbs_pkg

// File: verilog/dbs_if.sv
// Purpose: carries the lane steering controls between top and the write mux
// Assumes: one clock domain
// Notes: purely combinational path from sequencer state to lane pattern
`timescale 1ns/1ps
interface dbs_if;
  logic [1:0] size; // remaining-size code of the next bus cycle
  logic [1:0] offset; // byte offset of the next bus cycle
  logic [31:0] operand; // operand, msb byte first
  logic [31:0] lanes; // replicated write lane pattern
  modport ctrl (output size, output offset, output operand, input lanes);
  modport mux (input size, input offset, input operand, output lanes);
endinterface : dbs_if

// File: verilog/dbs_write_mux.sv
// Purpose: internal-to-external write multiplexer with lane replication
// Assumes: operand bytes msb, second, third, lsb in bits 31..0
// Notes: filler byte lanes are driven but no port width ever takes them
`timescale 1ns/1ps
module dbs_write_mux (
  dbs_if.mux m // steering controls and lane result
);
  logic [7:0] operand_byte_msb; // first operand byte
  logic [7:0] operand_byte_second; // second operand byte
  logic [7:0] operand_byte_third; // third operand byte
  logic [7:0] operand_byte_lsb; // last operand byte
  assign operand_byte_msb = m.operand[31:24];
  assign operand_byte_second = m.operand[23:16];
  assign operand_byte_third = m.operand[15:8];
  assign operand_byte_lsb = m.operand[7:0];

  // pattern per size and offset; lanes listed bits 31..24 first
  always_comb begin
    m.lanes = {4{operand_byte_lsb}}; // byte: every lane
    case (m.size)
      dbs_pkg::SIZE_BYTE: begin
        m.lanes = {4{operand_byte_lsb}}; // offset ignored
      end
      dbs_pkg::SIZE_WORD: begin
        // only the low offset bit matters
        if (m.offset[0]) begin
          m.lanes = {operand_byte_third, operand_byte_third, operand_byte_lsb,
            operand_byte_third};
        end else begin
          m.lanes = {operand_byte_third, operand_byte_lsb, operand_byte_third,
            operand_byte_lsb};
        end
      end
      dbs_pkg::SIZE_TRIP: begin
        case (m.offset)
          2'h0: m.lanes = {operand_byte_second, operand_byte_third, operand_byte_lsb,
            operand_byte_msb}; // msb is filler
          2'h1: m.lanes = {operand_byte_second, operand_byte_second, operand_byte_third,
            operand_byte_lsb};
          2'h2: m.lanes = {operand_byte_second, operand_byte_third, operand_byte_second,
            operand_byte_third};
          default: m.lanes = {operand_byte_second, operand_byte_second,
            operand_byte_third, operand_byte_second}; // third is filler
        endcase
      end
      default: begin
        case (m.offset)
          2'h0: m.lanes = m.operand; // natural order
          2'h1: m.lanes = {operand_byte_msb, operand_byte_msb, operand_byte_second,
            operand_byte_third};
          2'h2: m.lanes = {operand_byte_msb, operand_byte_second, operand_byte_msb,
            operand_byte_second};
          default: m.lanes = {operand_byte_msb, operand_byte_msb, operand_byte_second,
            operand_byte_msb}; // second is filler
        endcase
      end
    endcase
  end
endmodule : dbs_write_mux

// File: verilog/dbs_lane_steer.sv
// Purpose: dynamic bus sizing sequencer and lane steering for one operand
// Assumes: acknowledge lines come from pins and are synchronised here
// Notes: strobe timing, bus error and retry live elsewhere
`timescale 1ns/1ps
module dbs_lane_steer (
  input wire logic clk_i, // 50 MHz processor clock
  input wire logic reset_i, // synchronous, active high
  input wire logic start_i, // one-cycle request pulse, taken in idle
  input wire logic write_i, // 1 write, 0 read
  input wire logic fetch_i, // request is an instruction prefetch
  input wire logic [1:0] op_size_i, // operand size code, size encoding
  input wire logic [31:0] addr_i, // operand byte address
  input wire logic [31:0] wdata_i, // write operand, msb byte first
  input wire logic port_ack_upper_i, // acknowledge upper line, pin
  input wire logic port_ack_lower_i, // acknowledge lower line, pin
  input wire logic [31:0] data_in_i, // external data bus, pin
  output logic cycle_o, // bus cycle in progress
  output logic [31:0] addr_o, // current cycle address
  output logic remaining_size_hi_o, // size code high bit
  output logic remaining_size_lo_o, // size code low bit
  output logic [31:0] data_out_o, // external write data lanes
  output logic done_o, // one-cycle completion pulse
  output logic addr_err_o, // one-cycle address error pulse
  output logic [31:0] rdata_o, // assembled read operand
  output logic [1:0] cycles_o // bus cycles used minus one
);
  typedef struct packed {
    dbs_pkg::dbs_state_e st; // sequencer state
    logic [1:0] ack_m; // first sync stage
    logic [1:0] ack_s; // second sync stage
    logic [31:0] data_m; // data first sync stage
    logic [31:0] data_s; // data second sync stage
    logic wr; // transfer is a write
    logic [1:0] size; // bytes remaining code
    logic [31:0] addr; // current address
    logic [31:0] oper; // write operand
    logic [31:0] rd; // read assembly
    logic [31:0] lanes; // registered write lanes
    logic done; // completion pulse
    logic aerr; // address error pulse
    logic [1:0] ncyc; // cycle counter
  } dbs_state_s;

  dbs_state_s q; // registered state
  dbs_state_s d; // next state
  dbs_if sif (); // steering link to the write mux
  logic [2:0] rem; // bytes remaining, 1..4
  logic [2:0] room; // bytes the port can take this cycle
  logic [2:0] moved; // bytes moved this cycle
  logic [2:0] new_rem; // bytes left afterwards
  logic [2:0] base_lane; // lane index of first byte for the port
  logic [31:0] rd_next; // read assembly updated
  logic [1:0] nxt_size; // size code of the next bus cycle
  logic [31:0] nxt_addr; // address of the next bus cycle

  assign sif.size = nxt_size;
  assign sif.offset = nxt_addr[1:0];
  assign sif.operand = q.st == dbs_pkg::ST_IDLE ? wdata_i : q.oper;

  dbs_write_mux u_mux (
    .m(sif)
  );

  // bytes moved: remaining capped by lanes left in the port's width
  always_comb begin
    rem = q.size == dbs_pkg::SIZE_LONG ? 3'h4 : {1'h0, q.size};
    case (q.ack_s)
      dbs_pkg::ACK_P8: room = 3'h1;
      dbs_pkg::ACK_P16: room = 3'h2 - {2'h0, q.addr[0]};
      default: room = 3'h4 - {1'h0, q.addr[1:0]};
    endcase
    moved = rem < room ? rem : room;
    new_rem = rem - moved;
    // lane of first byte: 8- and 16-bit ports occupy top lanes only
    case (q.ack_s)
      dbs_pkg::ACK_P8: base_lane = 3'h3;
      dbs_pkg::ACK_P16: base_lane = 3'h3 - {2'h0, q.addr[0]};
      default: base_lane = 3'h3 - {1'h0, q.addr[1:0]};
    endcase
  end

  // read capture: byte i of the remaining tail lands at lane base-i
  always_comb begin
    logic [2:0] k;
    logic [2:0] lane;
    k = 3'h0;
    lane = 3'h0;
    rd_next = q.rd;
    for (int i = 0; i < 4; i++) begin
      k = rem - 3'(i) - 3'h1; // operand byte index from lsb
      lane = base_lane - 3'(i);
      if (3'(i) < moved) begin
        rd_next[{k[1:0], 3'h0} +: 8] = q.data_s[{lane[1:0], 3'h0} +: 8];
      end
    end
  end

  // next size and address kept apart from d, so the mux path never loops through d
  always_comb begin
    nxt_size = q.size;
    nxt_addr = q.addr;
    if (q.st == dbs_pkg::ST_IDLE && start_i && !(fetch_i && addr_i[0])) begin
      nxt_size = fetch_i ? dbs_pkg::SIZE_LONG : op_size_i; // largest first
      nxt_addr = addr_i;
    end else if (q.st == dbs_pkg::ST_CYC && q.ack_s != dbs_pkg::ACK_WAIT) begin
      nxt_addr = q.addr + 32'(moved); // e.g. 001 -> 010 -> 100
      nxt_size = new_rem[1:0]; // four left encodes as 00
    end
  end

  // next-state logic
  always_comb begin
    d = q;
    d.ack_m = {port_ack_upper_i, port_ack_lower_i};
    d.ack_s = q.ack_m;
    d.data_m = data_in_i;
    d.data_s = q.data_m;
    d.done = 1'b0;
    d.aerr = 1'b0;
    case (q.st)
      dbs_pkg::ST_IDLE: begin
        if (start_i) begin
          if (fetch_i && addr_i[0]) begin
            d.aerr = 1'b1; // no bus cycle for odd prefetch
          end else begin
            // misaligned data is simply split, no fault
            d.st = dbs_pkg::ST_CYC;
            d.wr = write_i;
            d.oper = wdata_i;
            d.rd = 32'h0;
            d.ncyc = 2'h0;
          end
        end
      end
      dbs_pkg::ST_CYC: begin
        if (q.ack_s != dbs_pkg::ACK_WAIT) begin
          if (!q.wr) begin
            d.rd = rd_next;
          end
          if (new_rem == 3'h0) begin
            d.st = dbs_pkg::ST_DONE;
            d.done = 1'b1;
          end else begin
            d.ncyc = q.ncyc + 2'h1; // follow-up cycle
          end
        end
      end
      dbs_pkg::ST_DONE: begin
        d.st = dbs_pkg::ST_IDLE;
      end
      default: begin
        d.st = dbs_pkg::ST_IDLE;
      end
    endcase
    d.size = nxt_size; // bytes still to move
    d.addr = nxt_addr; // advanced by bytes moved
    // next cycle's lanes; low bytes land on 31..16 in even-offset word cycles
    d.lanes = sif.lanes;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      q <= '0;
      q.st <= dbs_pkg::ST_IDLE;
      q.size <= dbs_pkg::SIZE_LONG;
    end else begin
      q <= d;
    end
  end

  assign cycle_o = q.st == dbs_pkg::ST_CYC;
  assign addr_o = q.addr;
  assign remaining_size_hi_o = q.size[1];
  assign remaining_size_lo_o = q.size[0];
  assign data_out_o = q.lanes;
  assign done_o = q.done;
  assign addr_err_o = q.aerr;
  assign rdata_o = q.rd;
  assign cycles_o = q.ncyc;

  // aligned long write starts with natural byte order
  property p_long_natural;
    @(posedge clk_i) disable iff (reset_i)
      (q.st == dbs_pkg::ST_IDLE && start_i && write_i && !fetch_i
        && op_size_i == dbs_pkg::SIZE_LONG && addr_i[1:0] == 2'h0)
      |=> (data_out_o == $past(wdata_i) && remaining_size_hi_o == 1'b0
        && remaining_size_lo_o == 1'b0);
  endproperty
  a_long_natural: assert property (p_long_natural) else $error("long write lanes wrong");

  // byte write on every lane
  property p_byte_rep;
    @(posedge clk_i) disable iff (reset_i)
      (cycle_o && q.wr && q.size == dbs_pkg::SIZE_BYTE)
      |-> (data_out_o == {4{q.oper[7:0]}});
  endproperty
  a_byte_rep: assert property (p_byte_rep) else $error("byte not replicated");

  // odd prefetch gives address error and no cycle
  property p_odd_fetch;
    @(posedge clk_i) disable iff (reset_i)
      (q.st == dbs_pkg::ST_IDLE && start_i && fetch_i && addr_i[0])
      |=> (addr_err_o && !cycle_o);
  endproperty
  a_odd_fetch: assert property (p_odd_fetch) else $error("odd fetch not refused");

  // 16-bit ack on aligned long gives word at offset 10
  property p_half_long;
    @(posedge clk_i) disable iff (reset_i)
      (cycle_o && q.size == dbs_pkg::SIZE_LONG && q.addr[1:0] == 2'h0
        && q.ack_s == dbs_pkg::ACK_P16)
      |=> (cycle_o && q.size == dbs_pkg::SIZE_WORD && q.addr[1:0] == 2'h2);
  endproperty
  a_half_long: assert property (p_half_long) else $error("long split wrong");

  // follow-up word write carries low two bytes on upper lanes
  property p_low_upper;
    @(posedge clk_i) disable iff (reset_i)
      (cycle_o && q.wr && q.size == dbs_pkg::SIZE_WORD && q.addr[1:0] == 2'h2)
      |-> (data_out_o[31:16] == q.oper[15:0]);
  endproperty
  a_low_upper: assert property (p_low_upper) else $error("word lanes wrong");

  // 8-bit ack on word steps to one byte remaining
  property p_word_byte;
    @(posedge clk_i) disable iff (reset_i)
      (cycle_o && q.size == dbs_pkg::SIZE_WORD && q.ack_s == dbs_pkg::ACK_P8)
      |=> (cycle_o && q.size == dbs_pkg::SIZE_BYTE);
  endproperty
  a_word_byte: assert property (p_word_byte) else $error("word to byte port wrong");

  // misaligned long on 16-bit: 001 long, then 010 three bytes
  property p_mis_two;
    @(posedge clk_i) disable iff (reset_i)
      (cycle_o && q.size == dbs_pkg::SIZE_LONG && q.addr[2:0] == 3'h1
        && q.ack_s == dbs_pkg::ACK_P16)
      |=> (q.size == dbs_pkg::SIZE_TRIP && q.addr[2:0] == 3'h2);
  endproperty
  a_mis_two: assert property (p_mis_two) else $error("second cycle wrong");

  // then 100 with one byte left
  property p_mis_three;
    @(posedge clk_i) disable iff (reset_i)
      (cycle_o && q.size == dbs_pkg::SIZE_TRIP && q.addr[2:0] == 3'h2
        && q.ack_s == dbs_pkg::ACK_P16)
      |=> (q.size == dbs_pkg::SIZE_BYTE && q.addr[2:0] == 3'h4);
  endproperty
  a_mis_three: assert property (p_mis_three) else $error("third cycle wrong");

  // completion: one done pulse with the bus idle, then still idle
  sequence s_finish;
    done_o && !cycle_o ##1 !cycle_o;
  endsequence

  // 32-bit ack always finishes the transfer when aligned
  property p_full_done;
    @(posedge clk_i) disable iff (reset_i)
      (cycle_o && q.ack_s == dbs_pkg::ACK_P32 && q.addr[1:0] == 2'h0)
      |=> s_finish;
  endproperty
  a_full_done: assert property (p_full_done) else $error("32-bit not done");
endmodule : dbs_lane_steer

// File: sim/dbs_slave_model.sv
// Purpose: slave port answering bus cycles with a chosen width
// Assumes: one clock; ack pulse one clock long with read data
// Notes: moves only the bytes its port room allows; idle lanes toggle
`timescale 1ns/1ps
module dbs_slave_model (
  input wire logic clk_i, // bus clock
  input wire logic cycle_i, // bus cycle running
  input wire logic write_i, // 1 write
  input wire logic [31:0] addr_i, // cycle address
  input wire logic [1:0] size_i, // remaining-size code
  input wire logic [31:0] data_i, // write lanes
  input wire logic [1:0] port_i, // width code to answer with
  input wire logic [3:0] wait_i, // extra wait clocks
  output logic ack_upper_o, // upper acknowledge
  output logic ack_lower_o, // lower acknowledge
  output logic [31:0] data_o // read lanes
);
  logic [7:0] mem [0:63]; // byte store
  logic [1:0] log_size [0:7]; // size code per answered cycle
  logic [31:0] log_addr [0:7]; // address per answered cycle
  logic [31:0] log_data [0:7]; // write lanes per answered cycle
  int n_log = 0; // answered cycles
  logic [33:0] last = '0; // address and size last seen
  logic served = 1'b0; // cycle already answered
  int cnt = 0; // clocks spent in this cycle
  // preload a known pattern
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 8'(i * 7 + 3);
    ack_upper_o = 1'b0;
    ack_lower_o = 1'b0;
    data_o = '0;
  end
  // answer each cycle once; a new address or size means a new cycle
  always @(posedge clk_i) begin
    int mask, room, rem, ln;
    ack_upper_o <= 1'b0;
    ack_lower_o <= 1'b0;
    data_o <= ~data_o; // released lanes never hold old data
    if (!cycle_i || {addr_i, size_i} != last) begin
      served = 1'b0;
      cnt = 0;
    end
    last = {addr_i, size_i};
    mask = (port_i == dbs_pkg::ACK_P32) ? 3 : (port_i == dbs_pkg::ACK_P16) ? 1 : 0;
    room = mask + 1 - (addr_i[1:0] & mask);
    rem = (size_i == 2'h0) ? 4 : int'(size_i);
    if (rem < room) room = rem;
    if (cycle_i && !served) begin
      if (cnt == wait_i + 1) begin
        served = 1'b1;
        {ack_upper_o, ack_lower_o} <= port_i;
        // fixed lanes per port width, filler lanes never taken
        for (int j = 0; j < room; j++) begin
          ln = 3 - ((addr_i[1:0] + j) & mask);
          if (write_i) mem[6'(addr_i[5:0] + j)] = data_i[8*ln +: 8];
          else data_o[8*ln +: 8] <= mem[6'(addr_i[5:0] + j)];
        end
        if (n_log < 8) begin
          log_size[n_log] = size_i;
          log_addr[n_log] = addr_i;
          log_data[n_log] = data_i;
        end
        n_log++;
      end else cnt++;
    end
  end
endmodule : dbs_slave_model

// File: sim/tb.sv
// Purpose: self-checking bench for the lane steering block
// Assumes: slave model answers; inputs change at falling edges
// Notes: expectations are worked out here from byte order and port room
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'b0; // 50 MHz
  logic reset_i = 1'b1; // held 12 clocks
  logic start_i = 1'b0, write_i = 1'b0, fetch_i = 1'b0; // request
  logic [1:0] op_size_i = 2'h0; // operand size
  logic [31:0] addr_i = 32'h0, wdata_i = 32'h0; // operand
  logic [1:0] port = dbs_pkg::ACK_P32; // slave width
  logic [3:0] wt = 4'h0; // slave wait clocks
  logic ack_u, ack_l, cyc, done, aerr, s_hi, s_lo, got_err;
  logic [31:0] a_o, dout, din, rdata;
  logic [1:0] ncy;
  int fails = 0;
  int compares = 0;
  always #10 clk_i = ~clk_i;
  dbs_lane_steer uut (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i),
    .write_i(write_i), .fetch_i(fetch_i), .op_size_i(op_size_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .port_ack_upper_i(ack_u), .port_ack_lower_i(ack_l),
    .data_in_i(din), .cycle_o(cyc), .addr_o(a_o), .remaining_size_hi_o(s_hi),
    .remaining_size_lo_o(s_lo), .data_out_o(dout), .done_o(done),
    .addr_err_o(aerr), .rdata_o(rdata), .cycles_o(ncy));
  dbs_slave_model slave (.clk_i(clk_i), .cycle_i(cyc), .write_i(write_i),
    .addr_i(a_o), .size_i({s_hi, s_lo}), .data_i(dout), .port_i(port),
    .wait_i(wt), .ack_upper_o(ack_u), .ack_lower_o(ack_l), .data_o(din));
  // compare tasks, one per result kind
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask : chk2
  // one whole operand transfer, bounded wait on done or error
  task automatic xfer(input logic w, f, input logic [1:0] sz, input logic [31:0] a, d);
    int k;
    @(negedge clk_i);
    {write_i, fetch_i, op_size_i, addr_i, wdata_i, start_i} = {w, f, sz, a, d, 1'b1};
    slave.n_log = 0;
    @(negedge clk_i);
    start_i = 1'b0;
    for (k = 0; k < 300 && done !== 1'b1 && aerr !== 1'b1; k++) @(negedge clk_i);
    got_err = aerr;
    chk(32'(k < 300), 32'h1);
    chk({31'h0, cyc}, 32'h0);
    @(negedge clk_i); // done state passes before the next start
  endtask : xfer
  // written bytes land big-endian from the address up
  task automatic wmem(input logic [31:0] a, input int n, input logic [31:0] d);
    for (int i = 0; i < n; i++) chk(32'(slave.mem[6'(a + i)]), 32'(d[8*(n-1-i) +: 8]));
  endtask : wmem
  function automatic logic [31:0] eread(input logic [31:0] a, input int n);
    logic [31:0] e;
    e = '0;
    for (int i = 0; i < n; i++) e = {e[23:0], 8'(6'(a + i) * 7 + 3)};
    return e;
  endfunction : eread
  // bus cycles needed: each moves min(remaining, port room)
  function automatic int ncyc(input int p, input int rem, input logic [31:0] a);
    int mask, room, c;
    mask = (p == 3) ? 3 : (p == 2) ? 1 : 0;
    c = 0;
    while (rem > 0) begin
      room = mask + 1 - (a[1:0] & mask);
      if (room > rem) room = rem;
      rem -= room;
      a += room;
      c++;
    end
    return c;
  endfunction : ncyc
  task automatic t_long16();
    port = dbs_pkg::ACK_P16;
    xfer(1'b1, 1'b0, dbs_pkg::SIZE_LONG, 32'h10, 32'h11223344); // aligned
    chk2(slave.log_size[0], dbs_pkg::SIZE_LONG);
    chk(slave.log_data[0], 32'h11223344);
    chk2(slave.log_size[1], dbs_pkg::SIZE_WORD);
    chk(slave.log_addr[1], 32'h12);
    chk({16'h0, slave.log_data[1][31:16]}, 32'h3344);
    chk2(ncy, 2'h1);
    wmem(32'h10, 4, 32'h11223344);
    $display("t_long16 done");
  endtask : t_long16
  task automatic t_word8();
    port = dbs_pkg::ACK_P8;
    xfer(1'b1, 1'b0, dbs_pkg::SIZE_WORD, 32'h21, 32'hABCD);
    chk2(slave.log_size[0], dbs_pkg::SIZE_WORD);
    chk2(slave.log_size[1], dbs_pkg::SIZE_BYTE);
    chk(slave.log_addr[1], 32'h22);
    wmem(32'h21, 2, 32'hABCD);
    $display("t_word8 done");
  endtask : t_word8
  task automatic t_mis16();
    port = dbs_pkg::ACK_P16;
    xfer(1'b1, 1'b0, dbs_pkg::SIZE_LONG, 32'h31, 32'hA1B2C3D4);
    chk2({1'b0, got_err}, 2'h0);
    chk2(slave.log_size[0], dbs_pkg::SIZE_LONG);
    chk2(slave.log_size[1], dbs_pkg::SIZE_TRIP);
    chk(slave.log_addr[1], 32'h32);
    chk2(slave.log_size[2], dbs_pkg::SIZE_BYTE);
    chk(slave.log_addr[2], 32'h34);
    chk2(ncy, 2'h2);
    wmem(32'h31, 4, 32'hA1B2C3D4);
    $display("t_mis16 done");
  endtask : t_mis16
  task automatic t_wmux();
    port = dbs_pkg::ACK_P32;
    for (int o = 0; o < 4; o++) begin
      xfer(1'b1, 1'b0, dbs_pkg::SIZE_BYTE, 32'(56 + o), 32'h5A);
      chk(slave.log_data[0], 32'h5A5A5A5A);
    end
    xfer(1'b1, 1'b0, dbs_pkg::SIZE_WORD, 32'h3C, 32'h1234);
    chk(slave.log_data[0], 32'h12341234);
    xfer(1'b1, 1'b0, dbs_pkg::SIZE_WORD, 32'h3D, 32'h5678);
    chk(slave.log_data[0], 32'h56567856);
    xfer(1'b1, 1'b0, dbs_pkg::SIZE_LONG, 32'h25, 32'hC1C2C3C4);
    chk(slave.log_data[0], 32'hC1C1C2C3);
    chk(slave.log_data[1], 32'hC4C4C4C4);
    xfer(1'b1, 1'b0, dbs_pkg::SIZE_LONG, 32'h2B, 32'hD1D2D3D4);
    chk({24'h0, slave.log_data[0][7:0]}, 32'hD1);
    wmem(32'h2B, 4, 32'hD1D2D3D4);
    $display("t_wmux done");
  endtask : t_wmux
  task automatic t_reads();
    for (int p = 1; p < 4; p++) for (int s = 0; s < 4; s++) for (int o = 0; o < 4; o++) begin
      port = 2'(p);
      wt = 4'(o);
      xfer(1'b0, 1'b0, 2'(s), 32'(4 + o), 32'h0);
      chk(rdata, eread(32'(4 + o), (s == 0) ? 4 : s));
      chk2(slave.log_size[0], 2'(s));
      chk2(ncy, 2'(ncyc(p, (s == 0) ? 4 : s, 32'(4 + o)) - 1));
    end
    $display("t_reads done");
  endtask : t_reads
  task automatic t_fetch();
    port = dbs_pkg::ACK_P16;
    xfer(1'b0, 1'b1, dbs_pkg::SIZE_BYTE, 32'h9, 32'h0);
    chk2({1'b0, got_err}, 2'h1);
    chk(32'(slave.n_log), 32'h0);
    xfer(1'b0, 1'b1, dbs_pkg::SIZE_BYTE, 32'h8, 32'h0);
    chk(rdata, eread(32'h8, 4));
    chk2(ncy, 2'h1);
    $display("t_fetch done");
  endtask : t_fetch
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // watchdog: the full run needs well under 10,000 clocks
  initial begin
    #400000;
    fails++;
    final_report();
  end
  initial begin
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    t_long16();
    t_word8();
    t_mis16();
    t_wmux();
    t_reads();
    t_fetch();
    final_report();
  end
endmodule : tb
